// file: verilog/sensor_serial_host_port.v
`timescale 1ns/10ps
`default_nettype none
`include "serial_port_map.vh"

module sensor_serial_host_port (
  input wire i_clk,
  input wire i_resetn,
  input wire i_scl,
  input wire i_serial_in_line,
  output wire o_sda_out,
  output wire o_sda_oe_n,
  output wire o_scl_out,
  output wire o_scl_oe_n,
  input wire i_port_select_n,
  output wire o_serial_out_line,
  output wire o_serial_out_line_oe_n,
  input wire i_addr_lsb_pin,
  input wire i_two_wire_port_disable,
  output wire o_bus_busy,
  output wire o_wr_valid,
  output wire [`IDX_W-1:0] o_wr_index,
  output wire [`BYTE_W-1:0] o_wr_data,
  input wire i_wr_ready,
  output wire [`IDX_W-1:0] o_rd_index,
  input wire [`BYTE_W-1:0] i_rd_data
);

  // Two-wire states
  localparam [2:0] TW_IDLE = 3'b000;
  localparam [2:0] TW_ADDR = 3'b001;
  localparam [2:0] TW_INDEX = 3'b010;
  localparam [2:0] TW_WDATA = 3'b011;
  localparam [2:0] TW_RDATA = 3'b100;
  localparam [2:0] TW_IGNORE = 3'b101;

  // ==========================================================
  // Pin synchronisers
  wire [`SYNC_W-1:0] pins_sync;
  wire scl_s;
  wire sda_s;
  wire cs_n_s;
  wire lsb_s;
  wire dis_s;

  pin_sync #(
    .W(`SYNC_W)
  ) u_sync (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_async({i_two_wire_port_disable, i_addr_lsb_pin, i_port_select_n,
              i_serial_in_line, i_scl}),
    .o_sync(pins_sync)
  );

  assign scl_s = pins_sync[0];
  assign sda_s = pins_sync[1];
  assign cs_n_s = pins_sync[2];
  assign lsb_s = pins_sync[3];
  assign dis_s = pins_sync[4];

  // ==========================================================
  // State registers
  reg scl_d_reg;
  reg sda_d_reg;
  reg [2:0] tw_state_reg;
  reg [`CNT_W-1:0] tw_cnt_reg;
  reg [`BYTE_W-1:0] tw_shift_reg;
  reg tw_rw_reg;
  reg sda_low_reg;
  reg scl_low_reg;
  reg pend_reg;
  reg busy_reg;
  reg [`IDX_W-1:0] index_reg;
  reg push_valid_reg;
  reg [`WORD_W-1:0] push_data_reg;
  reg [2:0] spi_cnt_reg;
  reg spi_data_phase_reg;
  reg spi_rw_reg;
  reg [`BYTE_W-1:0] spi_shift_reg;
  reg [`BYTE_W-1:0] spi_tx_reg;
  reg sdo_reg;
  reg sdo_oe_n_reg;
  reg sda_oe_n_reg;
  reg scl_oe_n_reg;

  // ==========================================================
  // Edge and condition detection
  wire scl_rise;
  wire scl_fall;
  wire start_ev;
  wire stop_ev;
  wire tw_en;
  wire tw_live;
  wire buf_in_ready;
  wire [`BYTE_W-1:0] spi_byte;
  wire [`IDX_W-1:0] own_addr;

  assign scl_rise = scl_s & ~scl_d_reg;
  assign scl_fall = ~scl_s & scl_d_reg;
  // Data edges while clock stays high
  assign start_ev = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_ev = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  // Two-wire side is off while disabled or while selected
  assign tw_en = ~dis_s & cs_n_s;
  assign tw_live = (tw_state_reg != TW_IDLE) &&
                   (tw_state_reg != TW_IGNORE);
  assign own_addr = {`TW_ADDR_HI, lsb_s};
  assign spi_byte = {spi_shift_reg[`BYTE_W-2:0], sda_s};

  // ==========================================================
  // Protocol engines
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      tw_state_reg <= TW_IDLE;
      tw_cnt_reg <= `BIT_ZERO;
      tw_shift_reg <= `BYTE_RESET;
      tw_rw_reg <= 1'b0;
      sda_low_reg <= 1'b0;
      scl_low_reg <= 1'b0;
      pend_reg <= 1'b0;
      busy_reg <= 1'b0;
      index_reg <= `IDX_RESET;
      push_valid_reg <= 1'b0;
      push_data_reg <= {`WORD_W{1'b0}};
      spi_cnt_reg <= `SPI_ZERO;
      spi_data_phase_reg <= 1'b0;
      spi_rw_reg <= 1'b0;
      spi_shift_reg <= `BYTE_RESET;
      spi_tx_reg <= `BYTE_RESET;
      sdo_reg <= 1'b0;
      sdo_oe_n_reg <= 1'b1;
      sda_oe_n_reg <= 1'b1;
      scl_oe_n_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
      push_valid_reg <= 1'b0;
      sda_oe_n_reg <= ~sda_low_reg;
      scl_oe_n_reg <= ~scl_low_reg;

      // Two-wire slave
      if (!tw_en) begin
        tw_state_reg <= TW_IDLE;
        sda_low_reg <= 1'b0;
        scl_low_reg <= 1'b0;
        pend_reg <= 1'b0;
        busy_reg <= 1'b0;
      end else if (start_ev) begin
        // First or repeated start readdresses
        busy_reg <= 1'b1;
        tw_state_reg <= TW_ADDR;
        tw_cnt_reg <= `BIT_ZERO;
        sda_low_reg <= 1'b0;
        scl_low_reg <= 1'b0;
        pend_reg <= 1'b0;
      end else if (stop_ev) begin
        busy_reg <= 1'b0;
        tw_state_reg <= TW_IDLE;
        sda_low_reg <= 1'b0;
        scl_low_reg <= 1'b0;
        pend_reg <= 1'b0;
      end else if (pend_reg) begin
        // Clock held low until the buffer takes the byte
        if (buf_in_ready && !push_valid_reg) begin
          push_valid_reg <= 1'b1;
          push_data_reg <= {index_reg, tw_shift_reg};
          pend_reg <= 1'b0;
          sda_low_reg <= 1'b1;
          scl_low_reg <= 1'b0;
        end
      end else if (scl_rise && tw_live) begin
        if (tw_cnt_reg < `BIT_ACK && tw_state_reg != TW_RDATA) begin
          tw_shift_reg <= {tw_shift_reg[`BYTE_W-2:0], sda_s};
        end
        tw_cnt_reg <= tw_cnt_reg + `BIT_ONE;
        // Master answer on the ninth pulse of a read byte
        if (tw_cnt_reg == `BIT_ACK && tw_state_reg == TW_RDATA) begin
          if (sda_s) begin
            tw_state_reg <= TW_IGNORE;
          end else begin
            index_reg <= index_reg + `IDX_STEP;
          end
        end
      end else if (scl_fall && tw_live) begin
        // All data changes follow a falling clock
        if (tw_cnt_reg == `BIT_ACK) begin
          case (tw_state_reg)
            TW_ADDR: begin
              if (tw_shift_reg[`BYTE_W-1:1] == own_addr) begin
                sda_low_reg <= 1'b1;
                tw_rw_reg <= tw_shift_reg[0];
              end else begin
                tw_state_reg <= TW_IGNORE;
              end
            end
            TW_INDEX: begin
              sda_low_reg <= 1'b1;
              index_reg <= tw_shift_reg[`IDX_W-1:0];
            end
            TW_WDATA: begin
              pend_reg <= 1'b1;
              scl_low_reg <= 1'b1;
            end
            default: begin
              sda_low_reg <= 1'b0;
            end
          endcase
        end else if (tw_cnt_reg == `BIT_DONE) begin
          tw_cnt_reg <= `BIT_ZERO;
          sda_low_reg <= 1'b0;
          case (tw_state_reg)
            TW_ADDR: begin
              if (tw_rw_reg == `RW_READ) begin
                tw_state_reg <= TW_RDATA;
                sda_low_reg <= ~i_rd_data[`BYTE_W-1];
                tw_shift_reg <= {i_rd_data[`BYTE_W-2:0], 1'b0};
              end else begin
                tw_state_reg <= TW_INDEX;
              end
            end
            TW_INDEX: begin
              tw_state_reg <= TW_WDATA;
            end
            TW_WDATA: begin
              index_reg <= index_reg + `IDX_STEP;
            end
            TW_RDATA: begin
              sda_low_reg <= ~i_rd_data[`BYTE_W-1];
              tw_shift_reg <= {i_rd_data[`BYTE_W-2:0], 1'b0};
            end
            default: begin
              tw_state_reg <= TW_IGNORE;
            end
          endcase
        end else if (tw_state_reg == TW_RDATA) begin
          sda_low_reg <= ~tw_shift_reg[`BYTE_W-1];
          tw_shift_reg <= {tw_shift_reg[`BYTE_W-2:0], 1'b0};
        end
      end

      // Four-wire slave
      if (cs_n_s) begin
        spi_cnt_reg <= `SPI_ZERO;
        spi_data_phase_reg <= 1'b0;
        sdo_oe_n_reg <= 1'b1;
      end else begin
        sdo_oe_n_reg <= 1'b0;
        if (scl_rise) begin
          spi_shift_reg <= spi_byte;
          spi_cnt_reg <= spi_cnt_reg + `SPI_ONE;
          if (spi_cnt_reg == `SPI_LAST) begin
            if (!spi_data_phase_reg) begin
              // Command byte opens every access
              spi_data_phase_reg <= 1'b1;
              spi_rw_reg <= spi_byte[`BYTE_W-1];
              index_reg <= spi_byte[`IDX_W-1:0];
            end else if (spi_rw_reg == `RW_READ) begin
              index_reg <= index_reg + `IDX_STEP;
            end else begin
              if (buf_in_ready && !push_valid_reg) begin
                push_valid_reg <= 1'b1;
                push_data_reg <= {index_reg, spi_byte};
              end
              index_reg <= index_reg + `IDX_STEP;
            end
          end
        end else if (scl_fall && spi_data_phase_reg &&
                     spi_rw_reg == `RW_READ) begin
          if (spi_cnt_reg == `SPI_ZERO) begin
            sdo_reg <= i_rd_data[`BYTE_W-1];
            spi_tx_reg <= {i_rd_data[`BYTE_W-2:0], 1'b0};
          end else begin
            sdo_reg <= spi_tx_reg[`BYTE_W-1];
            spi_tx_reg <= {spi_tx_reg[`BYTE_W-2:0], 1'b0};
          end
        end
      end
    end
  end

  // ==========================================================
  // Write path buffer
  wire [`WORD_W-1:0] buf_out_data;

  word_buffer2 u_buf (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_in_valid(push_valid_reg),
    .o_in_ready(buf_in_ready),
    .i_in_data(push_data_reg),
    .o_out_valid(o_wr_valid),
    .o_out_data(buf_out_data),
    .i_out_ready(i_wr_ready)
  );

  // Output pins, open drain value is low whenever driven
  assign o_wr_index = buf_out_data[`WORD_W-1:`BYTE_W];
  assign o_wr_data = buf_out_data[`BYTE_W-1:0];
  assign o_rd_index = index_reg;
  assign o_sda_out = sda_oe_n_reg;
  assign o_sda_oe_n = sda_oe_n_reg;
  assign o_scl_out = scl_oe_n_reg;
  assign o_scl_oe_n = scl_oe_n_reg;
  assign o_serial_out_line = sdo_reg;
  assign o_serial_out_line_oe_n = sdo_oe_n_reg;
  assign o_bus_busy = busy_reg;

endmodule // sensor_serial_host_port

`default_nettype wire

// file: verilog/serial_port_map.vh
`ifndef SERIAL_PORT_MAP_VH
`define SERIAL_PORT_MAP_VH

// ==========================================================
// Widths
`define BYTE_W 8
`define IDX_W 7
`define WORD_W 15
`define CNT_W 4
`define SYNC_W 5

// ==========================================================
// Two-wire address and bit counting
`define TW_ADDR_HI 6'h34
`define RW_READ 1'b1
`define BIT_ZERO 4'h0
`define BIT_ONE 4'h1
`define BIT_ACK 4'h8
`define BIT_DONE 4'h9

// ==========================================================
// Four-wire bit counting
`define SPI_ZERO 3'h0
`define SPI_ONE 3'h1
`define SPI_LAST 3'h7

// ==========================================================
// Register index handling
`define IDX_RESET 7'h00
`define IDX_STEP 7'h01
`define BYTE_RESET 8'h00

`endif

// file: verilog/pin_sync.v
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// Two-flop synchroniser, one chain per pin
module pin_sync #(
  parameter W = 5
) (
  input wire i_clk,
  input wire i_resetn,
  input wire [W-1:0] i_async,
  output wire [W-1:0] o_sync
);

  genvar g;

  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      reg meta_reg;
      reg sync_reg;
      // First stage feeds only the second stage
      always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          meta_reg <= 1'b1;
          sync_reg <= 1'b1;
        end else begin
          meta_reg <= i_async[g];
          sync_reg <= meta_reg;
        end
      end
      assign o_sync[g] = sync_reg;
    end
  endgenerate

endmodule // pin_sync

`default_nettype wire

// file: verilog/word_buffer2.v
`timescale 1ns/10ps
`default_nettype none
`include "serial_port_map.vh"

// ==========================================================
// Two-entry buffer, head entry drives the outputs
module word_buffer2 (
  input wire i_clk,
  input wire i_resetn,
  input wire i_in_valid,
  output wire o_in_ready,
  input wire [`WORD_W-1:0] i_in_data,
  output wire o_out_valid,
  output wire [`WORD_W-1:0] o_out_data,
  input wire i_out_ready
);

  reg head_valid_reg;
  reg spare_valid_reg;
  reg [`WORD_W-1:0] head_data_reg;
  reg [`WORD_W-1:0] spare_data_reg;
  wire pop;
  wire push;

  // Handshakes on both sides
  assign pop = head_valid_reg & i_out_ready;
  assign push = i_in_valid & ~spare_valid_reg;
  assign o_in_ready = ~spare_valid_reg;
  assign o_out_valid = head_valid_reg;
  assign o_out_data = head_data_reg;

  // Fill head first, spill into spare while head stalls
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      head_valid_reg <= 1'b0;
      spare_valid_reg <= 1'b0;
      head_data_reg <= {`WORD_W{1'b0}};
      spare_data_reg <= {`WORD_W{1'b0}};
    end else if (pop) begin
      if (spare_valid_reg) begin
        head_data_reg <= spare_data_reg;
        spare_valid_reg <= 1'b0;
      end else if (push) begin
        head_data_reg <= i_in_data;
      end else begin
        head_valid_reg <= 1'b0;
      end
    end else if (push) begin
      if (!head_valid_reg) begin
        head_valid_reg <= 1'b1;
        head_data_reg <= i_in_data;
      end else begin
        spare_valid_reg <= 1'b1;
        spare_data_reg <= i_in_data;
      end
    end
  end

endmodule // word_buffer2

`default_nettype wire

// file: tb/serial_port_checker.sv
`timescale 1ns/10ps
`default_nettype none
`include "serial_port_map.vh"

// ==========================================================
// Port checker
module serial_port_checker (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_scl,
  input wire logic i_serial_in_line,
  input wire logic o_sda_out,
  input wire logic o_scl_out,
  input wire logic o_sda_oe_n,
  input wire logic o_scl_oe_n,
  input wire logic i_port_select_n,
  input wire logic o_serial_out_line,
  input wire logic o_serial_out_line_oe_n,
  input wire logic i_two_wire_port_disable,
  input wire logic o_bus_busy,
  input wire logic o_wr_valid,
  input wire logic [`IDX_W-1:0] o_wr_index,
  input wire logic [`BYTE_W-1:0] o_wr_data,
  input wire logic i_wr_ready
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  // Start and stop as seen on the raw pins
  sequence start_s;
    $fell(i_serial_in_line) && i_scl && i_port_select_n
      && !i_two_wire_port_disable;
  endsequence
  sequence stop_s;
    $rose(i_serial_in_line) && i_scl && o_bus_busy;
  endsequence

  chk_busy_start: assert property (start_s |-> ##[1:5] o_bus_busy)
    else $error("busy not raised after start");
  chk_busy_stop: assert property (stop_s |-> ##[1:5] !o_bus_busy)
    else $error("busy not dropped after stop");
  chk_ack_hold: assert property (
    $rose(i_scl) && !o_sda_oe_n |-> !o_sda_oe_n [*8])
    else $error("data pull-down dropped while clock high");
  chk_sda_low_clk: assert property (
    $changed(o_sda_oe_n) && $stable(o_scl_oe_n) |-> !i_scl)
    else $error("data changed while clock high");
  chk_stretch_busy: assert property (!o_scl_oe_n |-> o_bus_busy)
    else $error("clock held low outside a transfer");
  chk_sda_drive_low: assert property (!o_sda_oe_n |-> !o_sda_out)
    else $error("data line driven high");
  chk_scl_drive_low: assert property (!o_scl_oe_n |-> !o_scl_out)
    else $error("clock line driven high");
  chk_so_float: assert property (
    i_port_select_n [*4] |-> o_serial_out_line_oe_n)
    else $error("serial out driven while deselected");
  chk_so_drive: assert property (
    !i_port_select_n [*4] |-> !o_serial_out_line_oe_n)
    else $error("serial out not driven while selected");
  chk_so_steady: assert property (
    !i_port_select_n && i_scl && $past(i_scl) && !o_serial_out_line_oe_n
      && $past(!o_serial_out_line_oe_n) |-> $stable(o_serial_out_line))
    else $error("serial out changed while clock high");
  chk_word_hold: assert property (
    o_wr_valid && !i_wr_ready |=> o_wr_valid && $stable(o_wr_index)
      && $stable(o_wr_data))
    else $error("write word changed before taken");
endmodule // serial_port_checker

bind sensor_serial_host_port serial_port_checker chk_i (.*);

`default_nettype wire

// file: tb/host_master_model.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// Host bus master for both links
module host_master_model (
  input wire logic i_sda_oe_n,
  input wire logic i_scl_oe_n,
  input wire logic i_so,
  output wire logic o_scl,
  output wire logic o_din,
  output var logic o_sel_n
);
  localparam real H = 62.5; // Half of the 125 ns link period
  logic scl_m = 1'b1;
  logic din_m = 1'b1;
  int stuck = 0;
  initial o_sel_n = 1'b1;

  // Open-drain wires with pull-ups
  assign o_scl = scl_m & i_scl_oe_n;
  assign o_din = din_m & i_sda_oe_n;

  // Raise clock, wait out a stretch, bounded
  task automatic rise();
    scl_m = 1'b1;
    for (int k = 0; k < 2000 && !o_scl; k++) #5;
    if (!o_scl) stuck++;
  endtask
  // One bit, data set while clock low
  task automatic bit_x(input logic b, output logic r);
    din_m = b;
    #H;
    rise();
    #(H/2) r = o_din;
    #(H/2) scl_m = 1'b0;
  endtask
  // Byte then acknowledge slot
  task automatic tw_xfer(input logic [7:0] d, input logic ak_m,
                         output logic [7:0] q, output logic ak);
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(ak_m, ak);
  endtask
  // Start or repeated start
  task automatic tw_start();
    din_m = 1'b1;
    #H;
    rise();
    #H din_m = 1'b0;
    #H scl_m = 1'b0;
  endtask
  task automatic tw_stop();
    din_m = 1'b0;
    #H;
    rise();
    #H din_m = 1'b1;
    #H;
  endtask
  // Four-wire byte: change on fall, sample on rise
  task automatic spi_xfer(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      scl_m = 1'b0;
      din_m = d[i];
      #H scl_m = 1'b1;
      q[i] = i_so;
      #H;
    end
  endtask
  task automatic sel(input logic b);
    o_sel_n = b;
    din_m = 1'b1;
    #H;
  endtask
endmodule // host_master_model

`default_nettype wire

// file: tb/sensor_serial_host_port_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "serial_port_map.vh"

// ==========================================================
// Bench top
module sensor_serial_host_port_tb;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic pin = 1'b1;
  logic dis = 1'b0;
  logic rdy = 1'b1;
  int str = 0;
  logic [7:0] rdd = 8'h00;
  logic [7:0] q;
  logic a;
  int num_errors = 0;
  int checked = 0;
  int cyc = 0;
  logic [14:0] got[$];
  wire scl, din, sel_n, sda_oe_n, scl_oe_n, so, so_oe_n, busy, wv;
  wire [`IDX_W-1:0] wi, ri;
  wire [`BYTE_W-1:0] wd;

  sensor_serial_host_port uut (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_scl(scl),
    .i_serial_in_line(din), .o_sda_out(), .o_sda_oe_n(sda_oe_n),
    .o_scl_out(), .o_scl_oe_n(scl_oe_n), .i_port_select_n(sel_n),
    .o_serial_out_line(so), .o_serial_out_line_oe_n(so_oe_n),
    .i_addr_lsb_pin(pin), .i_two_wire_port_disable(dis),
    .o_bus_busy(busy), .o_wr_valid(wv), .o_wr_index(wi),
    .o_wr_data(wd), .i_wr_ready(rdy), .o_rd_index(ri), .i_rd_data(rdd));
  host_master_model m (.i_sda_oe_n(sda_oe_n), .i_scl_oe_n(scl_oe_n),
    .i_so(so), .o_scl(scl), .o_din(din), .o_sel_n(sel_n));

  initial forever #2.5 i_clk = ~i_clk;

  // Register file side, stretch cycle count, timeout
  always @(posedge i_clk) begin
    rdd <= {1'b0, ri} ^ 8'hA5;
    if (wv === 1'b1 && rdy === 1'b1) got.push_back({wi, wd});
    if (scl_oe_n === 1'b0) str <= str + 1;
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      num_errors++;
      give_verdict();
    end
  end

  // ==========================================================
  // Shared tasks
  task chk(input string n, input logic [14:0] e, input logic [14:0] s);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task word(input logic [14:0] e);
    repeat (8) @(posedge i_clk);
    chk("word", e, got.size() ? got.pop_front() : 15'hx);
  endtask
  task give_verdict();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task t_reset();
    chk("idle", 15'h0380, {busy, wv, sda_oe_n, scl_oe_n, so_oe_n, ri});
  endtask
  // Burst write with receiver stalled, buffer fills
  task t_tw_write();
    @(posedge i_clk) rdy <= 1'b0;
    m.tw_start();
    chk("busy", 1, busy);
    m.tw_xfer({7'h69, 1'b0}, 1'b1, q, a);
    chk("ack", 0, a);
    m.tw_xfer(8'h10, 1'b1, q, a);
    chk("ack", 0, a);
    fork
      begin
        repeat (1500) @(posedge i_clk);
        rdy <= 1'b1;
      end
      for (int i = 0; i < 3; i++) begin
        m.tw_xfer(8'hA0 + 8'(i), 1'b1, q, a);
        chk("ack", 0, a);
      end
    join
    chk("stretch", 1, str > 500);
    m.tw_stop();
    chk("busy", 0, busy);
    for (int i = 0; i < 3; i++) word({7'h10 + 7'(i), 8'hA0 + 8'(i)});
    chk("drained", 0, wv);
  endtask
  // Index write, repeated start, two-byte read
  task t_tw_read();
    m.tw_start();
    m.tw_xfer({7'h69, 1'b0}, 1'b1, q, a);
    m.tw_xfer(8'h20, 1'b1, q, a);
    m.tw_start();
    chk("busy", 1, busy);
    m.tw_xfer({7'h69, 1'b1}, 1'b1, q, a);
    chk("ack", 0, a);
    m.tw_xfer(8'hFF, 1'b0, q, a);
    chk("rd", 8'h20 ^ 8'hA5, q);
    m.tw_xfer(8'hFF, 1'b1, q, a);
    chk("rd", 8'h21 ^ 8'hA5, q);
    m.tw_stop();
    chk("busy", 0, busy);
  endtask
  // Address follows the address LSB pin
  task t_addr();
    @(posedge i_clk) pin <= 1'b0;
    for (int j = 0; j < 2; j++) begin
      m.tw_start();
      m.tw_xfer({6'h34, j[0], 1'b0}, 1'b1, q, a);
      chk("ack", j, a);
      m.tw_stop();
    end
  endtask
  // Four-wire burst write then burst read
  task t_spi();
    m.sel(1'b0);
    chk("so_oe_n", 0, so_oe_n);
    m.spi_xfer(8'h05, q);
    m.spi_xfer(8'h11, q);
    m.spi_xfer(8'h22, q);
    m.sel(1'b1);
    chk("so_oe_n", 1, so_oe_n);
    word({7'h05, 8'h11});
    word({7'h06, 8'h22});
    m.sel(1'b0);
    m.spi_xfer(8'hB0, q);
    m.spi_xfer(8'hFF, q);
    chk("rd", 8'h30 ^ 8'hA5, q);
    m.spi_xfer(8'hFF, q);
    chk("rd", 8'h31 ^ 8'hA5, q);
    m.sel(1'b1);
  endtask
  // Two-wire side shut off
  task t_disable();
    @(posedge i_clk) dis <= 1'b1;
    m.tw_start();
    m.tw_xfer({7'h68, 1'b0}, 1'b1, q, a);
    chk("ack", 1, a);
    chk("busy", 0, busy);
    m.tw_stop();
    @(posedge i_clk) dis <= 1'b0;
  endtask

  // Main sequence
  initial begin
    repeat (2) @(posedge i_clk);
    i_resetn <= 1'b1;
    repeat (4) @(posedge i_clk);
    t_reset();
    t_tw_write();
    t_tw_read();
    t_addr();
    t_spi();
    t_disable();
    chk("stuck", 0, m.stuck);
    give_verdict();
  end
endmodule // sensor_serial_host_port_tb

`default_nettype wire
